// ==== core/dcs_pkg.sv ====
// Shared constants, carriers and state encoding for the comparator D debug block.
`default_nettype none
package dcs_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [11:0] IDX_D_CTL = 12'h140;
  localparam logic [11:0] IDX_D_AH = 12'h145;
  localparam logic [11:0] IDX_D_AM = 12'h146;
  localparam logic [11:0] IDX_D_AL = 12'h147;
  localparam logic [11:0] IDX_DC1 = 12'h100;
  localparam logic [11:0] IDX_DC2 = 12'h101;
  localparam logic [11:0] IDX_STAT = 12'h102;
  localparam logic [11:0] IDX_TRACE = 12'h10e;
  localparam logic [11:0] IDX_C_CTL = 12'h130;

  // Comparator control field positions.
  localparam int unsigned CTL_PC_COMPARE_SELECT = 5;
  localparam int unsigned CTL_RW = 3;
  localparam int unsigned CTL_RWE = 2;
  localparam int unsigned CTL_COMPARATOR_ON = 0;

  // Debug control one and two field positions.
  localparam int unsigned DC1_ARM = 7;
  localparam int unsigned DC1_FORCE_TRIGGER_BIT = 6;
  localparam int unsigned DC2_RANGE_MODE_SELECT_CD_LSB = 0;
  localparam int unsigned DC2_TGT_LSB = 2;

  // Status field positions.
  localparam int unsigned ST_TRACE_BIT = 0;
  localparam int unsigned ST_STATE_LSB = 1;
  localparam int unsigned ST_PTA_BIT = 4;
  localparam int unsigned ST_COUNT_LSB = 5;

  // Reset values.
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [7:0] DC_RST = 8'h00;

  // Widths and trace buffer shape.
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned TRACE_W = 16;
  localparam int unsigned TRACE_DEPTH = 16;
  localparam int unsigned TRACE_CNT_W = 5;

  // CPU data access seen on the bus.
  typedef struct packed {
    logic valid;
    logic rnw;
    logic [23:0] addr;
  } dcs_access_t;

  // Opcode entering the execution stage.
  typedef struct packed {
    logic valid;
    logic [23:0] pc;
  } dcs_exec_t;

  // Sequencer states, Gray coded along idle, 1, 2, 3, final.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ONE = 3'b001,
    ST_TWO = 3'b011,
    ST_THREE = 3'b010,
    ST_FINAL = 3'b110
  } dcs_state_t;

endpackage
`default_nettype wire

// ==== core/dcs_comparator.sv ====
// Address comparator with access direction qualification and opcode mode.
`timescale 1ns/1ps
`default_nettype none
module dcs_comparator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] ctl,
  input wire logic [23:0] cmp_addr,
  input wire dcs_pkg::dcs_access_t access,
  input wire dcs_pkg::dcs_exec_t exec,
  output logic match
);
  import dcs_pkg::*;

  logic dir_ok;
  logic data_hit;
  logic pc_hit;

  // Direction qualification passes unless enabled and mismatched.
  // direction equal test
  assign dir_ok = !ctl[CTL_RWE] || (ctl[CTL_RW] == access.rnw);
  assign data_hit = access.valid && (access.addr == cmp_addr) && dir_ok;
  assign pc_hit = exec.valid && (exec.pc == cmp_addr);
  assign match = ctl[CTL_COMPARATOR_ON] && (ctl[CTL_PC_COMPARE_SELECT] ? pc_hit : data_hit);

  AST_PC_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
    ctl[CTL_COMPARATOR_ON] && ctl[CTL_PC_COMPARE_SELECT] && exec.valid && exec.pc == cmp_addr |-> match)
    else $error("opcode address match not raised");
  AST_ADDR_EXACT: assert property (@(posedge pclk) disable iff (!presetn)
    match && !ctl[CTL_PC_COMPARE_SELECT] |-> access.addr == cmp_addr)
    else $error("data match with unequal address");
  AST_RW_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
    ctl[CTL_RWE] && !ctl[CTL_PC_COMPARE_SELECT] && (ctl[CTL_RW] != access.rnw) |-> !match)
    else $error("match despite direction mismatch");
  AST_PC_COMPARE_SELECT_IGNORES_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    ctl[CTL_COMPARATOR_ON] && ctl[CTL_PC_COMPARE_SELECT] |-> match == (exec.valid && exec.pc == cmp_addr))
    else $error("opcode match depends on direction");

endmodule
`default_nettype wire

// ==== core/dcs_trace_buf.sv ====
// Trace buffer of 16-bit entries, drained one word per window read.
`timescale 1ns/1ps
`default_nettype none
module dcs_trace_buf (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [15:0] push_data,
  input wire logic pop,
  output logic [15:0] head,
  output logic empty,
  output logic full,
  output logic [4:0] count
);
  import dcs_pkg::*;

  logic [TRACE_W-1:0] mem [TRACE_DEPTH];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [4:0] count_reg;
  logic do_push;
  logic do_pop;

  // Pushes stop at full so old entries are kept, pops are ignored when empty.
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign empty = (count_reg == 5'h00);
  assign full = (count_reg == 5'(TRACE_DEPTH));
  assign count = count_reg;
  assign head = mem[rd_ptr_reg];

  // Storage write.
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      count_reg <= count_reg + 5'(do_push) - 5'(do_pop);
    end
  end

  AST_TRACE_POP: assert property (@(posedge pclk) disable iff (!presetn)
    pop && !empty && !push |=> count == $past(count) - 5'h01)
    else $error("trace read did not remove one entry");

endmodule
`default_nettype wire

// ==== core/dcs_debug_top.sv ====
// Comparator D debug block: APB registers, sequencer and trace window.
// Contract
// - Control bit 5 selects program counter compare (1) or data address compare (0).
// - Control bit 3 picks write (0) or read (1) cycles, unused if unqualified or opcode mode.
// - Control bit 2 turns direction qualification on, ignored in opcode mode.
// - Control bit 0 enables the comparator, which never matches while it is 0.
// - Qualified matches need the bus direction equal to the value bit.
// - Comparator D registers read anytime and write only when disarmed and profiling is idle.
// - In C/D range mode the C control register configures the compare and D control is unused.
// - The 24-bit stored address, reset to zero, must equal the bus address bit for bit.
// - Tracing and breakpoints happen only while the arm bit is set.
// - In data mode a data access at the stored address matches.
// - In opcode mode the match rises as the opcode enters execution.
// - A comparator match moves the sequencer to the programmed state.
// - The sequencer moves freely among states 1, 2 and 3 and the final state starts tracing.
// - The external event or a force trigger write forces the sequencer to the final state.
// - The trace buffer is read through a two-byte window by 16-bit reads.
// - Opcode mode ignores direction bits and needs the exact first opcode byte address.
`timescale 1ns/1ps
`default_nettype none
module dcs_debug_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dcs_pkg::dcs_access_t cpu_access,
  input wire dcs_pkg::dcs_exec_t cpu_exec,
  input wire logic external_event,
  input wire logic profiling_trace_active,
  output logic match_d,
  output logic breakpoint,
  output logic trace_active,
  output dcs_pkg::dcs_state_t seq_state
);
  import dcs_pkg::*;

  // Register index match for a byte address.
  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    hit = (a[15:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  logic [7:0] d_ctl_reg;
  logic [23:0] d_addr_reg;
  logic [7:0] c_ctl_reg;
  logic [7:0] dc1_reg;
  logic [7:0] dc2_reg;
  logic [31:0] prdata_reg;
  logic breakpoint_reg;
  dcs_state_t state_reg;
  dcs_state_t state_next;
  logic wr_access;
  logic rd_setup;
  logic rd_access;
  logic mapped;
  logic d_wr_ok;
  logic arm;
  logic force_trigger_bit_write;
  logic forced;
  logic range_mode;
  logic [7:0] eff_ctl;
  logic [1:0] target;
  dcs_state_t target_state;
  logic [15:0] trace_head;
  logic trace_empty;
  logic trace_full;
  logic [4:0] trace_count;
  logic trace_pop;
  logic trace_push;
  logic [31:0] rd_value;

  // APB phase decode; the slave always answers in the first access cycle.
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign mapped = hit(paddr, IDX_D_CTL) || hit(paddr, IDX_D_AH) || hit(paddr, IDX_D_AM)
    || hit(paddr, IDX_D_AL) || hit(paddr, IDX_DC1) || hit(paddr, IDX_DC2)
    || hit(paddr, IDX_STAT) || hit(paddr, IDX_TRACE) || hit(paddr, IDX_C_CTL);
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // Control decode.
  assign arm = dc1_reg[DC1_ARM];
  assign d_wr_ok = !arm && !profiling_trace_active;
  assign force_trigger_bit_write = wr_access && hit(paddr, IDX_DC1) && pwdata[DC1_FORCE_TRIGGER_BIT];
  assign forced = force_trigger_bit_write || external_event;
  assign range_mode = (dc2_reg[DC2_RANGE_MODE_SELECT_CD_LSB +: 2] != 2'b00);
  assign eff_ctl = range_mode ? c_ctl_reg : d_ctl_reg;
  assign target = dc2_reg[DC2_TGT_LSB +: 2];

  // Comparator D against the CPU buses.
  // mode select inside comparator
  dcs_comparator u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(eff_ctl),
    .cmp_addr(d_addr_reg),
    .access(cpu_access),
    .exec(cpu_exec),
    .match(match_d)
  );

  // Comparator D registers; a blocked write changes nothing.
  // locked writes dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_ctl_reg <= CTL_RST;
      d_addr_reg <= ADDR_RST;
    end else if (wr_access && d_wr_ok) begin
      if (hit(paddr, IDX_D_CTL)) begin
        d_ctl_reg <= pwdata[7:0];
      end
      if (hit(paddr, IDX_D_AH)) begin
        d_addr_reg[23:16] <= pwdata[7:0];
      end
      if (hit(paddr, IDX_D_AM)) begin
        d_addr_reg[15:8] <= pwdata[7:0];
      end
      if (hit(paddr, IDX_D_AL)) begin
        d_addr_reg[7:0] <= pwdata[7:0];
      end
    end
  end

  // Comparator C control and range select share the same lock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_ctl_reg <= CTL_RST;
      dc2_reg <= DC_RST;
    end else if (wr_access && d_wr_ok) begin
      if (hit(paddr, IDX_C_CTL)) begin
        c_ctl_reg <= pwdata[7:0];
      end
      if (hit(paddr, IDX_DC2)) begin
        dc2_reg <= pwdata[7:0];
      end
    end
  end

  // Debug control one; the force trigger bit is a write pulse and reads as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc1_reg <= DC_RST;
    end else if (wr_access && hit(paddr, IDX_DC1)) begin
      dc1_reg <= pwdata[7:0] & ~(8'h01 << DC1_FORCE_TRIGGER_BIT);
    end
  end

  // Target state of a comparator match.
  always_comb begin
    case (target)
      2'b00: target_state = ST_ONE;
      2'b01: target_state = ST_TWO;
      2'b10: target_state = ST_THREE;
      default: target_state = ST_FINAL;
    endcase
  end

  // Sequencer next state; forced moves beat comparator matches.
  always_comb begin
    state_next = state_reg;
    if (!arm) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = forced ? ST_FINAL : ST_ONE;
        end
        ST_ONE, ST_TWO, ST_THREE: begin
          if (forced) begin
            state_next = ST_FINAL;
          end else if (match_d) begin
            state_next = target_state;
          end
        end
        ST_FINAL: begin
          state_next = ST_FINAL;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Breakpoint pulse on entry to the final state.
  // final entry triggers tracing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breakpoint_reg <= 1'b0;
    end else begin
      breakpoint_reg <= (state_next == ST_FINAL) && (state_reg != ST_FINAL);
    end
  end

  assign breakpoint = breakpoint_reg;
  assign seq_state = state_reg;
  assign trace_active = (state_reg == ST_FINAL);

  // Trace capture of data access addresses while in the final state.
  // capture only when armed
  assign trace_push = trace_active && arm && cpu_access.valid;
  assign trace_pop = rd_access && hit(paddr, IDX_TRACE);

  dcs_trace_buf u_trace (
    .pclk(pclk),
    .presetn(presetn),
    .push(trace_push),
    .push_data(cpu_access.addr[15:0]),
    .pop(trace_pop),
    .head(trace_head),
    .empty(trace_empty),
    .full(trace_full),
    .count(trace_count)
  );

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_value = 32'h00000000;
    if (hit(paddr, IDX_D_CTL)) begin
      rd_value[7:0] = d_ctl_reg;
    end else if (hit(paddr, IDX_D_AH)) begin
      rd_value[7:0] = d_addr_reg[23:16];
    end else if (hit(paddr, IDX_D_AM)) begin
      rd_value[7:0] = d_addr_reg[15:8];
    end else if (hit(paddr, IDX_D_AL)) begin
      rd_value[7:0] = d_addr_reg[7:0];
    end else if (hit(paddr, IDX_DC1)) begin
      rd_value[7:0] = dc1_reg;
    end else if (hit(paddr, IDX_DC2)) begin
      rd_value[7:0] = dc2_reg;
    end else if (hit(paddr, IDX_C_CTL)) begin
      rd_value[7:0] = c_ctl_reg;
    end else if (hit(paddr, IDX_STAT)) begin
      rd_value[ST_TRACE_BIT] = trace_active;
      rd_value[ST_STATE_LSB +: 3] = state_reg;
      rd_value[ST_PTA_BIT] = profiling_trace_active;
      rd_value[ST_COUNT_LSB +: 5] = trace_count;
    end else if (hit(paddr, IDX_TRACE)) begin
      rd_value[15:0] = trace_empty ? 16'h0000 : trace_head;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_value;
    end
  end

  // Steps of a final state entry.
  sequence enter_final_s;
    state_reg != ST_FINAL ##1 state_reg == ST_FINAL;
  endsequence

  AST_D_WRITE_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && (arm || profiling_trace_active) |=> $stable(d_ctl_reg) && $stable(d_addr_reg))
    else $error("comparator D register changed while locked");
  AST_NO_MATCH_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !eff_ctl[CTL_COMPARATOR_ON] |-> !match_d)
    else $error("match while comparator disabled");
  AST_ARM_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !arm |=> state_reg == ST_IDLE && !trace_active)
    else $error("sequencer active while disarmed");
  AST_FORCE_FINAL: assert property (@(posedge pclk) disable iff (!presetn)
    arm && forced |=> state_reg == ST_FINAL)
    else $error("forced transition did not reach final state");
  AST_FINAL_TRACE: assert property (@(posedge pclk) disable iff (!presetn)
    enter_final_s |-> breakpoint && trace_active)
    else $error("final entry without trace start");
  AST_MATCH_MOVES: assert property (@(posedge pclk) disable iff (!presetn)
    arm && !forced && match_d && state_reg != ST_IDLE && state_reg != ST_FINAL
    |=> state_reg == $past(target_state))
    else $error("match did not move sequencer to target");
  AST_RANGE_USES_C: assert property (@(posedge pclk) disable iff (!presetn)
    range_mode && !c_ctl_reg[CTL_COMPARATOR_ON] |-> !match_d)
    else $error("comparator D control used in range mode");

endmodule
`default_nettype wire

// ==== sim/dcs_cpu_model.sv ====
// CPU bus and instruction queue model, one bus cycle per call.
`timescale 1ns/1ps
`default_nettype none
module dcs_cpu_model (
  input wire logic pclk,
  output dcs_pkg::dcs_access_t access,
  output dcs_pkg::dcs_exec_t exec
);
  import dcs_pkg::*;
  // Both buses start idle.
  initial begin
    access = '0;
    exec = '0;
  end
  // Drives one cycle; an idle bus shows the inverse of its last value.
  // access and opcode
  task automatic step(input logic dv, input logic rnw, input logic [23:0] da, input logic ev,
    input logic [23:0] pc);
    @(posedge pclk);
    access <= dv ? {1'b1, rnw, da} : {1'b0, ~access.rnw, ~access.addr};
    exec <= ev ? {1'b1, pc} : {1'b0, ~exec.pc};
    #1;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_debug_comparator_d_and_sequencer.sv ====
// Self-checking bench for the comparator D debug block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_debug_comparator_d_and_sequencer;
  import dcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, external_event, profiling_trace_active;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, match_d, breakpoint, trace_active, err;
  dcs_access_t cpu_access;
  dcs_exec_t cpu_exec;
  dcs_state_t seq_state;
  dcs_state_t tgt [4] = '{ST_ONE, ST_TWO, ST_THREE, ST_FINAL};
  int err_count = 0;
  int n_tests = 0;
  int seed = 66508;
  logic [7:0] ctl;
  logic [23:0] da;
  logic [15:0] q [$];

  dcs_debug_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_access(cpu_access), .cpu_exec(cpu_exec),
    .external_event(external_event), .profiling_trace_active(profiling_trace_active),
    .match_d(match_d), .breakpoint(breakpoint), .trace_active(trace_active),
    .seq_state(seq_state));
  dcs_cpu_model u_cpu (.pclk(pclk), .access(cpu_access), .exec(cpu_exec));

  // Free running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Writes comparator D control and address.
  task automatic wd(input logic [7:0] c, input logic [23:0] a);
    apb(1'b1, IDX_D_CTL, {24'h0, c});
    apb(1'b1, IDX_D_AH, {24'h0, a[23:16]});
    apb(1'b1, IDX_D_AM, {24'h0, a[15:8]});
    apb(1'b1, IDX_D_AL, {24'h0, a[7:0]});
  endtask

  // Reads comparator D back and compares.
  task automatic rdchk(input logic [7:0] c, input logic [23:0] a);
    apb(1'b0, IDX_D_CTL, 32'h0);
    `CHK("ctl", c & 8'h2d, rd[7:0] & 8'h2d)
    apb(1'b0, IDX_D_AH, 32'h0);
    `CHK("addr_hi", a[23:16], rd[7:0])
    apb(1'b0, IDX_D_AM, 32'h0);
    `CHK("addr_mid", a[15:8], rd[7:0])
    apb(1'b0, IDX_D_AL, 32'h0);
    `CHK("addr_lo", a[7:0], rd[7:0])
  endtask

  task automatic nop();
    u_cpu.step(1'b0, 1'b0, 24'h0, 1'b0, 24'h0);
  endtask

  // Waits a few cycles for a sequencer state.
  task automatic waitst(input dcs_state_t s);
    for (int i = 0; i < 4 && seq_state !== s; i++) nop();
  endtask

  // Expected comparator output for the current bus cycle.
  function automatic logic exp_m(input logic [7:0] c, input logic [23:0] a,
    input dcs_access_t ac, input dcs_exec_t ex);
    if (!c[CTL_COMPARATOR_ON]) return 1'b0;
    if (c[CTL_PC_COMPARE_SELECT]) return ex.valid && ex.pc == a;
    return ac.valid && ac.addr == a && (!c[CTL_RWE] || ac.rnw == c[CTL_RW]);
  endfunction

  // Hang guard.
  initial begin
    #100000;
    err_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, external_event, profiling_trace_active} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h00, 24'h0);
    apb(1'b0, 12'h141, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    for (int i = 0; i < 40; i++) begin
      ctl = 8'($random(seed));
      da = (i == 0) ? 24'hffffff : 24'($random(seed));
      wd(ctl, da);
      rdchk(ctl, da);
      for (int k = 0; k < 6; k++) begin
        u_cpu.step(1'($random(seed)), 1'($random(seed)), k[0] ? da : da ^ (24'h1 << (4 * k)),
          1'($random(seed)), k[1] ? da : ~da);
        `CHK("match", exp_m(ctl, da, cpu_access, cpu_exec), match_d)
      end
    end
    apb(1'b1, IDX_DC1, 32'h80);
    wd(~ctl, ~da);
    rdchk(ctl, da);
    u_cpu.step(1'b1, ctl[CTL_RW], da, 1'b1, da);
    `CHK("match_locked", exp_m(ctl, da, cpu_access, cpu_exec), match_d)
    apb(1'b1, IDX_DC1, 32'h0);
    @(posedge pclk);
    profiling_trace_active <= 1'b1;
    wd(~ctl, ~da);
    rdchk(ctl, da);
    @(posedge pclk);
    profiling_trace_active <= 1'b0;
    apb(1'b1, IDX_DC2, 32'h1);
    apb(1'b1, IDX_C_CTL, 32'h0);
    wd(8'h01, 24'h00abcd);
    u_cpu.step(1'b1, 1'b0, 24'h00abcd, 1'b0, 24'h0);
    `CHK("range_match", 1'b0, match_d)
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, IDX_DC1, 32'h0);
      apb(1'b1, IDX_DC2, t << 2);
      u_cpu.step(1'b1, 1'b0, 24'h00abcd, 1'b0, 24'h0);
      nop();
      `CHK("state_disarmed", ST_IDLE, seq_state)
      apb(1'b1, IDX_DC1, 32'h80);
      nop();
      `CHK("state_armed", ST_ONE, seq_state)
      u_cpu.step(1'b1, 1'b1, 24'h00abcd, 1'b0, 24'h0);
      `CHK("match_seq", 1'b1, match_d)
      nop();
      `CHK("state_target", tgt[t], seq_state)
      `CHK("breakpoint", t == 3, breakpoint)
      `CHK("trace_active", t == 3, trace_active)
      nop();
      `CHK("breakpoint_pulse", 1'b0, breakpoint)
    end
    apb(1'b1, IDX_DC1, 32'h0);
    apb(1'b1, IDX_DC1, 32'h80);
    nop();
    @(posedge pclk);
    external_event <= 1'b1;
    @(posedge pclk);
    external_event <= 1'b0;
    #1;
    `CHK("event_final", ST_FINAL, seq_state)
    `CHK("event_break", 1'b1, breakpoint)
    apb(1'b1, IDX_DC1, 32'h0);
    apb(1'b0, IDX_TRACE, 32'h0);
    `CHK("trace_empty", 16'h0, rd[15:0])
    apb(1'b1, IDX_DC1, 32'h80);
    nop();
    apb(1'b1, IDX_DC1, 32'hc0);
    waitst(ST_FINAL);
    `CHK("force_trigger_bit_final", ST_FINAL, seq_state)
    for (int i = 0; i < 17; i++) begin
      da = 24'($random(seed));
      if (i < 16) q.push_back(da[15:0]);
      u_cpu.step(1'b1, 1'($random(seed)), da, 1'b0, 24'h0);
    end
    nop();
    // Status shows the final state, tracing on and a full buffer.
    apb(1'b0, IDX_STAT, 32'h0);
    `CHK("status", (32'(TRACE_DEPTH) << ST_COUNT_LSB) | (32'(ST_FINAL) << ST_STATE_LSB) | (32'h1 << ST_TRACE_BIT), rd)
    q.push_back(16'h0);
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, IDX_TRACE, 32'h0);
      `CHK("trace_word", q[i], rd[15:0])
    end
    conclude();
  end
endmodule
`default_nettype wire
